//--- common/mrp_params.svh
`ifndef MRP_PARAMS_SVH
`define MRP_PARAMS_SVH

// Report identifiers used in shortcut mode
`define MRP_ID_MOUSE 8'h01
`define MRP_ID_KBD 8'h02
// Largest packet handed out per transfer
`define MRP_MAX_BYTES 4'h8
// Field positions inside the 12-bit motion words
`define MRP_LO_NIB 3:0
`define MRP_HI_NIB 11:8
`define MRP_MID_BYTE 11:4
`define MRP_LO_BYTE 7:0
// Fill values
`define MRP_ZERO_BYTE 8'h00
`define MRP_ZERO_LEN 4'h0
`define MRP_ONE_LEN 4'h1
// Button byte positions
`define MRP_BACK_BIT 3'h3
`define MRP_FWD_BIT 3'h4
// Keyboard report lengths, one or two shortcuts
`define MRP_KBD_LEN_ONE 4'h4
`define MRP_KBD_LEN_TWO 4'h5

`endif

//--- common/mrp_pkg.sv
package mrp_pkg;

  // Stored layout choice, captured while reset is held
  typedef struct packed {
    logic motion_12bit;
    logic five_buttons;
    logic back_only;
    logic tilt_enable;
    logic shortcut_mode;
    logic second_shortcut;
  } mrp_cfg_t;

  typedef struct packed {
    logic forward_button;
    logic back_button;
    logic middle_button;
    logic right_button;
    logic left_button;
  } mrp_buttons_t;

  // Two's-complement counts from the motion engine
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [7:0] z;
    logic [7:0] tilt_wheel_count;
  } mrp_motion_t;

  // One programmed shortcut: modifier flags and key code
  typedef struct packed {
    logic [7:0] modifiers;
    logic [7:0] key_code;
  } mrp_key_t;

  typedef struct packed {
    logic [7:0][7:0] bytes;
    logic [3:0] len;
    logic is_kbd;
  } mrp_pkt_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mrp_beat_t;

  typedef enum logic [1:0] {
    MRP_IDLE,
    MRP_SEND,
    MRP_WAIT_HS
  } mrp_state_t;

endpackage : mrp_pkg

//--- src/mrp_packer.sv
// Functional notes
// - 8-bit three-button report is buttons (middle, right, left in bits 2..0), X, Y, wheel.
// - With tilt enabled in 8-bit format and no shortcut mode a fifth tilt byte follows the wheel.
// - Five-button reports carry forward in bit 4 and back in bit 3, bits 7..5 zero.
// - When the fifth input is reassigned only back is reported in bit 3 and bit 4 stays zero.
// - 12-bit format sends X[7:0], then X[11:8] low nibble with Y[3:0] high nibble.
// - 12-bit format then sends Y[11:4], the wheel byte, and the tilt byte if enabled.
// - Shortcut mode prefixes every mouse report with identifier 1, shifting later bytes.
// - Keyboard reports carry identifier 2 then modifier flags, right GUI bit 7 to left Ctrl bit 0.
// - Keyboard byte 3 is zero, byte 4 the first key code, byte 5 the second where it exists.
// - 8-bit shortcut mode with tilt puts the tilt count in byte 6 of the mouse report.
// - 12-bit shortcut mode puts the wheel count in byte 6 of the mouse report.
// - Never more bytes than requested, at most eight, and a packet not acknowledged is resent.
`include "mrp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module mrp_packer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration: layout sampled while reset is held, shortcut keys read when a poll builds a new keyboard report
  input wire mrp_pkg::mrp_cfg_t cfg_in,
  input wire mrp_pkg::mrp_key_t first_key,
  input wire mrp_pkg::mrp_key_t second_key,
  // Button and shortcut pins
  input wire mrp_pkg::mrp_buttons_t buttons_pin,
  input wire logic first_shortcut_input,
  input wire logic second_shortcut_input,
  // Motion counts from the tracking engine
  input wire mrp_pkg::mrp_motion_t motion,
  output logic motion_taken,
  // Host poll and handshake
  input wire logic poll_req,
  input wire logic [15:0] poll_len,
  input wire logic host_ack,
  input wire logic host_nak,
  output logic busy,
  // Report byte stream
  output logic rep_valid,
  input wire logic rep_ready,
  output logic [7:0] rep_data,
  output logic rep_last
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  mrp_pkg::mrp_buttons_t btn_meta_q;
  mrp_pkg::mrp_buttons_t btn_q;
  logic [1:0] sc_meta_q;
  logic [1:0] sc_q;
  logic [1:0] sc_prev_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      btn_meta_q <= '0;
      btn_q <= '0;
      sc_meta_q <= '0;
      sc_q <= '0;
    end else begin
      btn_meta_q <= buttons_pin;
      btn_q <= btn_meta_q;
      sc_meta_q <= {second_shortcut_input, first_shortcut_input};
      sc_q <= sc_meta_q;
    end
  end

  // ****************************************
  // Configuration capture
  // ****************************************
  mrp_pkg::mrp_cfg_t cfg_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q <= cfg_in;
    end
  end

  // ****************************************
  // Report builders
  // ****************************************
  function automatic logic [7:0] mrp_button_byte(input mrp_pkg::mrp_cfg_t c,
                                                input mrp_pkg::mrp_buttons_t b);
    logic [7:0] v;
    v = {5'h00, b.middle_button, b.right_button, b.left_button};
    if (c.five_buttons) begin
      v[`MRP_BACK_BIT] = b.back_button;
      v[`MRP_FWD_BIT] = c.back_only ? 1'b0 : b.forward_button;
    end
    return v;
  endfunction : mrp_button_byte

  function automatic mrp_pkg::mrp_pkt_t mrp_mouse_pkt(input mrp_pkg::mrp_cfg_t c,
                                                     input mrp_pkg::mrp_buttons_t b,
                                                     input mrp_pkg::mrp_motion_t m);
    mrp_pkg::mrp_pkt_t p;
    logic [3:0] n;
    p = '0;
    n = `MRP_ZERO_LEN;
    if (c.shortcut_mode) begin
      p.bytes[n[2:0]] = `MRP_ID_MOUSE;
      n = n + `MRP_ONE_LEN;
    end
    p.bytes[n[2:0]] = mrp_button_byte(c, b);
    n = n + `MRP_ONE_LEN;
    p.bytes[n[2:0]] = m.x[`MRP_LO_BYTE];
    n = n + `MRP_ONE_LEN;
    if (c.motion_12bit) begin
      p.bytes[n[2:0]] = {m.y[`MRP_LO_NIB], m.x[`MRP_HI_NIB]};
      n = n + `MRP_ONE_LEN;
      p.bytes[n[2:0]] = m.y[`MRP_MID_BYTE];
    end else begin
      p.bytes[n[2:0]] = m.y[`MRP_LO_BYTE];
    end
    n = n + `MRP_ONE_LEN;
    p.bytes[n[2:0]] = m.z;
    n = n + `MRP_ONE_LEN;
    if (c.tilt_enable) begin
      p.bytes[n[2:0]] = m.tilt_wheel_count;
      n = n + `MRP_ONE_LEN;
    end
    p.len = n;
    p.is_kbd = 1'b0;
    return p;
  endfunction : mrp_mouse_pkt

  function automatic mrp_pkg::mrp_pkt_t mrp_kbd_pkt(input mrp_pkg::mrp_cfg_t c,
                                                   input logic [1:0] s,
                                                   input mrp_pkg::mrp_key_t ka,
                                                   input mrp_pkg::mrp_key_t kb);
    mrp_pkg::mrp_pkt_t p;
    logic [7:0] mods;
    logic [7:0] code_a;
    logic [7:0] code_b;
    p = '0;
    mods = `MRP_ZERO_BYTE;
    code_a = s[0] ? ka.key_code : `MRP_ZERO_BYTE;
    code_b = (s[1] && c.second_shortcut) ? kb.key_code : `MRP_ZERO_BYTE;
    if (s[0]) begin
      mods = mods | ka.modifiers;
    end
    if (s[1] && c.second_shortcut) begin
      mods = mods | kb.modifiers;
    end
    p.bytes[0] = `MRP_ID_KBD;
    p.bytes[1] = mods;
    p.bytes[2] = `MRP_ZERO_BYTE;
    p.bytes[3] = code_a;
    p.bytes[4] = code_b;
    p.len = c.second_shortcut ? `MRP_KBD_LEN_TWO : `MRP_KBD_LEN_ONE;
    p.is_kbd = 1'b1;
    return p;
  endfunction : mrp_kbd_pkt

  // ****************************************
  // Keyboard event tracking
  // ****************************************
  logic kbd_pending_q;
  logic hs_ack_kbd;
  logic sc_change;

  assign sc_change = cfg_q.shortcut_mode && (sc_q != sc_prev_q);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sc_prev_q <= '0;
      kbd_pending_q <= 1'b0;
    end else begin
      sc_prev_q <= sc_q;
      if (sc_change) begin
        kbd_pending_q <= 1'b1;
      end else if (hs_ack_kbd) begin
        kbd_pending_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Transfer control
  // ****************************************
  mrp_pkg::mrp_state_t state_q;
  mrp_pkg::mrp_pkt_t pkt_q;
  logic pkt_stale_q;
  logic [3:0] send_len_q;
  logic [3:0] send_idx_q;
  logic [3:0] avail;
  logic fifo_in_ready;
  logic push;
  logic push_last;

  assign avail = pkt_stale_q ? `MRP_ZERO_LEN : pkt_q.len;
  assign push = (state_q == mrp_pkg::MRP_SEND) && fifo_in_ready;
  assign push_last = (send_idx_q + `MRP_ONE_LEN) == send_len_q;
  assign hs_ack_kbd = (state_q == mrp_pkg::MRP_WAIT_HS) && host_ack && pkt_q.is_kbd;
  assign busy = state_q != mrp_pkg::MRP_IDLE;

  function automatic logic [3:0] mrp_clip_len(input logic [3:0] have,
                                             input logic [15:0] want);
    logic [3:0] v;
    v = have;
    if (want < {12'h000, v}) begin
      v = want[3:0];
    end
    if (v > `MRP_MAX_BYTES) begin
      v = `MRP_MAX_BYTES;
    end
    return v;
  endfunction : mrp_clip_len

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= mrp_pkg::MRP_IDLE;
      pkt_q <= '0;
      pkt_stale_q <= 1'b1;
      send_len_q <= `MRP_ZERO_LEN;
      send_idx_q <= `MRP_ZERO_LEN;
      motion_taken <= 1'b0;
    end else begin
      motion_taken <= 1'b0;
      unique case (state_q)
        mrp_pkg::MRP_IDLE: begin
          if (poll_req) begin
            send_idx_q <= `MRP_ZERO_LEN;
            if (pkt_stale_q) begin
              pkt_stale_q <= 1'b0;
              if (kbd_pending_q) begin
                pkt_q <= mrp_kbd_pkt(cfg_q, sc_q, first_key, second_key);
                send_len_q <= mrp_clip_len(mrp_kbd_pkt(cfg_q, sc_q, first_key,
                                                       second_key).len, poll_len);
              end else begin
                pkt_q <= mrp_mouse_pkt(cfg_q, btn_q, motion);
                send_len_q <= mrp_clip_len(mrp_mouse_pkt(cfg_q, btn_q, motion).len,
                                           poll_len);
              end
              state_q <= (poll_len == 16'h0000) ? mrp_pkg::MRP_WAIT_HS : mrp_pkg::MRP_SEND;
            end else begin
              send_len_q <= mrp_clip_len(avail, poll_len);
              state_q <= (poll_len == 16'h0000) ? mrp_pkg::MRP_WAIT_HS : mrp_pkg::MRP_SEND;
            end
          end
        end
        mrp_pkg::MRP_SEND: begin
          if (push) begin
            send_idx_q <= send_idx_q + `MRP_ONE_LEN;
            if (push_last) begin
              state_q <= mrp_pkg::MRP_WAIT_HS;
            end
          end
        end
        mrp_pkg::MRP_WAIT_HS: begin
          if (host_ack) begin
            pkt_stale_q <= 1'b1;
            motion_taken <= !pkt_q.is_kbd;
            state_q <= mrp_pkg::MRP_IDLE;
          end else if (host_nak) begin
            state_q <= mrp_pkg::MRP_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Two-entry output buffer
  // ****************************************
  mrp_pkg::mrp_beat_t buf_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic pop;

  assign fifo_in_ready = count_q != 2'h2;
  assign rep_valid = count_q != 2'h0;
  assign pop = rep_valid && rep_ready;
  assign rep_data = buf_q[rd_ptr_q].data;
  assign rep_last = rep_valid && buf_q[rd_ptr_q].last;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        buf_q[wr_ptr_q] <= '{data: pkt_q.bytes[send_idx_q[2:0]], last: push_last};
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : mrp_packer

`default_nettype wire

//--- verification/mrp_packer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mrp_packer_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host side inputs
  input wire mrp_pkg::mrp_cfg_t cfg_in,
  input wire logic poll_req,
  input wire logic [15:0] poll_len,
  input wire logic host_ack,
  input wire logic host_nak,
  input wire logic rep_ready,
  // Watched outputs
  input wire logic motion_taken,
  input wire logic busy,
  input wire logic rep_valid,
  input wire logic [7:0] rep_data,
  input wire logic rep_last
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] cnt_q;
  logic [15:0] len_q;
  logic done_q;
  logic kbd_q;
  wire logic take = poll_req && !busy;
  wire logic beat = rep_valid && rep_ready;
  // ****************
  // Transfer tracking
  // ****************
  always_ff @(posedge clk_sys) begin
    if (rst || take) begin
      cnt_q <= 16'h0000;
      done_q <= 1'b0;
      kbd_q <= 1'b0;
      len_q <= rst ? 16'h0000 : poll_len;
    end else if (beat) begin
      cnt_q <= cnt_q + 16'h0001;
      done_q <= rep_last;
      if (cnt_q == 16'h0000) begin
        kbd_q <= cfg_in.shortcut_mode && rep_data == 8'h02;
      end
    end
  end
  a_stall_hold: assert property (
    rep_valid && !rep_ready |=> rep_valid && $stable(rep_data) && $stable(rep_last))
    else $error("byte changed under stall");
  a_first_byte: assert property (
    take && poll_len != 16'h0000 |=> busy && !rep_valid ##1 rep_valid)
    else $error("first byte late");
  a_busy_hold: assert property (
    busy && !host_ack && !host_nak |=> busy) else $error("busy dropped early");
  a_hs_release: assert property (
    busy && done_q && (host_ack || host_nak) |=> !busy) else $error("busy stuck");
  a_byte_limit: assert property (
    beat |-> cnt_q < 16'h0008 && cnt_q < len_q) else $error("too many bytes");
  a_taken_ack: assert property (
    motion_taken |-> $past(host_ack)) else $error("counts cleared without ack");
  a_taken_mouse: assert property (
    busy && done_q && host_ack |=> motion_taken == !kbd_q)
    else $error("count clear pulse wrong after ack");
  a_idle_quiet: assert property (
    !busy |-> !rep_valid) else $error("byte outside transfer");
  a_report_id: assert property (
    beat && cnt_q == 16'h0000 && cfg_in.shortcut_mode |-> rep_data inside {8'h01, 8'h02})
    else $error("bad report id");
  a_button_top: assert property (
    beat && cnt_q == 16'h0000 && !cfg_in.shortcut_mode |-> rep_data[7:5] == 3'h0)
    else $error("button byte top bits set");
  c_stall: cover property (rep_valid && !rep_ready);
  c_nak: cover property (busy && host_nak);
  c_taken: cover property (motion_taken);
  c_kbd: cover property (beat && cnt_q == 16'h0000 && rep_data == 8'h02);
endmodule : mrp_packer_asserts
`default_nettype wire

//--- verification/mrp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mrp_host_model (
  // Clock
  input wire logic clk_sys,
  // Poll and handshake
  output logic poll_req,
  output logic [15:0] poll_len,
  output logic host_ack,
  output logic host_nak,
  // Report stream
  input wire logic rep_valid,
  output logic rep_ready,
  input wire logic [7:0] rep_data,
  input wire logic rep_last
);
  logic [7:0] got [8];
  int n;
  initial begin
    poll_req = 1'b0;
    poll_len = 16'h0000;
    host_ack = 1'b0;
    host_nak = 1'b0;
    rep_ready = 1'b0;
  end
  // ****************
  // One IN transfer
  // ****************
  task automatic poll(input logic [15:0] len, input logic nak, input logic slow);
    logic fin;
    n = 0;
    fin = 1'b0;
    @(posedge clk_sys);
    poll_req <= 1'b1;
    poll_len <= len;
    @(posedge clk_sys);
    poll_req <= 1'b0;
    poll_len <= ~len;
    for (int t = 0; t < 100 && !fin && !(len == 16'h0000 && t > 3); t++) begin
      rep_ready <= !slow || t[1:0] == 2'h3;
      @(posedge clk_sys);
      if (rep_valid && rep_ready) begin
        got[n] = rep_data;
        n++;
        fin = rep_last;
      end
    end
    rep_ready <= 1'b0;
    host_ack <= !nak;
    host_nak <= nak;
    @(posedge clk_sys);
    host_ack <= 1'b0;
    host_nak <= 1'b0;
    @(posedge clk_sys);
  endtask : poll
endmodule : mrp_host_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  mrp_pkg::mrp_cfg_t cfg_in;
  mrp_pkg::mrp_key_t first_key;
  mrp_pkg::mrp_key_t second_key;
  mrp_pkg::mrp_buttons_t buttons_pin;
  mrp_pkg::mrp_motion_t motion;
  logic first_shortcut_input;
  logic second_shortcut_input;
  logic poll_req, host_ack, host_nak, busy, rep_valid, rep_ready, rep_last, motion_taken;
  logic [15:0] poll_len;
  logic [7:0] rep_data;
  logic [7:0] e[$];
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  mrp_pkg::mrp_cfg_t cfgs[7] = '{6'h00, 6'h04, 6'h10, 6'h1C, 6'h34, 6'h07, 6'h32};
  always #25 clk_sys = ~clk_sys;
  mrp_packer u_mrp_packer (.clk_sys(clk_sys), .rst(rst), .cfg_in(cfg_in),
    .first_key(first_key), .second_key(second_key), .buttons_pin(buttons_pin),
    .first_shortcut_input(first_shortcut_input), .second_shortcut_input(second_shortcut_input),
    .motion(motion), .motion_taken(motion_taken), .poll_req(poll_req), .poll_len(poll_len),
    .host_ack(host_ack), .host_nak(host_nak), .busy(busy), .rep_valid(rep_valid),
    .rep_ready(rep_ready), .rep_data(rep_data), .rep_last(rep_last));
  mrp_host_model u_mrp_host_model (.clk_sys(clk_sys), .poll_req(poll_req),
    .poll_len(poll_len), .host_ack(host_ack), .host_nak(host_nak), .rep_valid(rep_valid),
    .rep_ready(rep_ready), .rep_data(rep_data), .rep_last(rep_last));
  // ****************
  // Tasks
  // ****************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cmp_pkt(input logic [15:0] len);
    int k;
    k = e.size() < len ? e.size() : len;
    check("count", 8'(u_mrp_host_model.n), 8'(k));
    for (int i = 0; i < k; i++) check("byte", u_mrp_host_model.got[i], e[i]);
  endtask : cmp_pkt
  task automatic build();
    e = {};
    if (cfg_in.shortcut_mode) e.push_back(8'h01);
    e.push_back({3'h0, cfg_in.five_buttons & ~cfg_in.back_only & buttons_pin.forward_button,
      cfg_in.five_buttons & buttons_pin.back_button, buttons_pin[2:0]});
    e.push_back(motion.x[7:0]);
    if (cfg_in.motion_12bit) e.push_back({motion.y[3:0], motion.x[11:8]});
    e.push_back(cfg_in.motion_12bit ? motion.y[11:4] : motion.y[7:0]);
    e.push_back(motion.z);
    if (cfg_in.tilt_enable) e.push_back(motion.tilt_wheel_count);
  endtask : build
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end
  initial begin
    cfg_in = 6'h00;
    first_key = {8'hA5, 8'h2B};
    second_key = {8'h3C, 8'h1D};
    buttons_pin = 5'h1A;
    motion = {12'hA53, 12'h6C9, 8'hF1, 8'h8E};
    first_shortcut_input = 1'b0;
    second_shortcut_input = 1'b0;
    foreach (cfgs[i]) begin
      @(posedge clk_sys);
      rst <= 1'b1;
      cfg_in <= cfgs[i];
      first_shortcut_input <= 1'b0;
      second_shortcut_input <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      build();
      u_mrp_host_model.poll(16'h0008, 1'b0, i[0]);
      cmp_pkt(16'h0008);
      if (cfg_in.shortcut_mode) begin
        first_shortcut_input <= 1'b1;
        second_shortcut_input <= cfg_in.second_shortcut;
        repeat (4) @(posedge clk_sys);
        e = {8'h02, cfg_in.second_shortcut ? 8'hBD : 8'hA5, 8'h00, 8'h2B};
        if (cfg_in.second_shortcut) e.push_back(8'h1D);
        u_mrp_host_model.poll(16'h0008, 1'b0, 1'b1);
        cmp_pkt(16'h0008);
        if (cfg_in.second_shortcut) begin
          second_shortcut_input <= 1'b0;
          repeat (4) @(posedge clk_sys);
          e = {8'h02, 8'hA5, 8'h00, 8'h2B, 8'h00};
          u_mrp_host_model.poll(16'h0008, 1'b0, 1'b0);
          cmp_pkt(16'h0008);
        end
      end
      $display("test config %0d done", i);
    end
    build();
    u_mrp_host_model.poll(16'h0000, 1'b1, 1'b0);
    cmp_pkt(16'h0000);
    u_mrp_host_model.poll(16'h0003, 1'b1, 1'b1);
    cmp_pkt(16'h0003);
    motion.x <= 12'h3C4;
    u_mrp_host_model.poll(16'h0008, 1'b0, 1'b0);
    cmp_pkt(16'h0008);
    build();
    u_mrp_host_model.poll(16'h0008, 1'b0, 1'b0);
    cmp_pkt(16'h0008);
    $display("test resend done");
    results();
  end
endmodule : testbench
bind mrp_packer mrp_packer_asserts u_mrp_packer_asserts (.clk_sys(clk_sys), .rst(rst),
  .cfg_in(cfg_in), .poll_req(poll_req), .poll_len(poll_len), .host_ack(host_ack),
  .host_nak(host_nak), .rep_ready(rep_ready), .motion_taken(motion_taken), .busy(busy),
  .rep_valid(rep_valid), .rep_data(rep_data), .rep_last(rep_last));
`default_nettype wire
